/* File: inc/dacf_pkg.sv */
// Constants, types and helpers of the audio clock and format control block.
// Assumes a 10 MHz system clock; sample clock pins are asynchronous to it.
package dacf_pkg;
   // ==========================================
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int FS_MIN_HZ = 25_000;
   localparam int FS_MAX_HZ = 102_000;
   localparam int FS_32K_HZ = 32_000;
   localparam int FS_44K_HZ = 44_100;
   localparam int FS_48K_HZ = 48_000;
   localparam int FS_64K_HZ = 64_000;
   localparam int FS_88K_HZ = 88_200;
   localparam int FS_96K_HZ = 96_000;
   localparam int PER_W = 12;
   // Shortest period rounds up, longest rounds down
   localparam logic [PER_W-1:0] PER_MIN = PER_W'((CLK_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ);
   localparam logic [PER_W-1:0] PER_MAX = PER_W'(CLK_HZ / FS_MIN_HZ);
   localparam logic [PER_W-1:0] PER_TOL = 12'h004;
   // ==========================================
   // Sample rate codes
   localparam logic [2:0] RATE_32K = 3'h0;
   localparam logic [2:0] RATE_44K = 3'h1;
   localparam logic [2:0] RATE_48K = 3'h2;
   localparam logic [2:0] RATE_64K = 3'h3;
   localparam logic [2:0] RATE_88K = 3'h4;
   localparam logic [2:0] RATE_96K = 3'h5;
   // ==========================================
   // Register map
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] STAT_OFS = 32'h0000_0004;
   localparam int CTL_BOOTED = 0;
   localparam int CTL_CLKMODE = 1;
   localparam int CTL_FORCE_MC = 3;
   localparam int CTL_FORCE_ST = 4;
   localparam int CTL_EMPH = 5;
   localparam int CTL_PRO = 6;
   localparam int CTL_NONAUDIO = 7;
   localparam int CTL_DIRMON = 8;
   localparam int CTL_MULTI_IN = 9;
   localparam int CTL_RATE = 12;
   localparam int CTL_TRACKS = 16;
   localparam int CTL_PAIR = 20;
   localparam logic [31:0] CTRL_MASK = 32'h003f_73ff;
   localparam logic [31:0] CTRL_RST = 32'h0002_2002;
   localparam int STA_SLAVE = 0;
   localparam int STA_IN_LOCK = 1;
   localparam int STA_IN_MC = 2;
   localparam int STA_OUT_MC = 3;
   localparam int STA_WC_LOCK = 4;
   localparam int STA_RATE = 5;
   localparam int STA_JUMPER = 8;
   localparam int STA_PERIOD = 16;
   localparam logic [1:0] CM_MASTER = 2'h0;
   localparam logic [1:0] CM_AUTO = 2'h1;
   localparam logic [1:0] CM_WORD = 2'h2;
   localparam logic [3:0] MC_TRACKS = 4'h2;
   // ==========================================
   // Channel status word
   localparam int CS_PRO = 0;
   localparam int CS_NONAUDIO = 1;
   localparam int CS_COPY = 2;
   localparam int CS_EMPH_CON = 3;
   localparam int CS_EMPH_PRO = 2;
   localparam int CS_RATE = 24;
   localparam logic [2:0] EMPH_NONE_CON = 3'h0;
   localparam logic [2:0] EMPH_5015_CON = 3'h1;
   localparam logic [2:0] EMPH_NONE_PRO = 3'h4;
   localparam logic [2:0] EMPH_5015_PRO = 3'h6;
   // ==========================================
   // Types
   typedef enum logic [1:0] {SRC_XTAL, SRC_INPUT, SRC_WORD} dacf_src_t;
   typedef struct packed {
      logic valid;
      logic [PER_W-1:0] period;
   } dacf_meas_t;
   typedef struct packed {
      logic out_multichan;
      logic elec_out_en;
      logic in_multichan;
      logic in_to_ch12;
      logic direct_mon;
      logic [1:0] stereo_pair;
   } dacf_route_t;
   // ==========================================
   // Helpers
   function automatic logic [PER_W-1:0] period_of(input logic [2:0] code);
      case (code)
         RATE_32K: period_of = PER_W'(CLK_HZ / FS_32K_HZ);
         RATE_44K: period_of = PER_W'(CLK_HZ / FS_44K_HZ);
         RATE_64K: period_of = PER_W'(CLK_HZ / FS_64K_HZ);
         RATE_88K: period_of = PER_W'(CLK_HZ / FS_88K_HZ);
         RATE_96K: period_of = PER_W'(CLK_HZ / FS_96K_HZ);
         default: period_of = PER_W'(CLK_HZ / FS_48K_HZ);
      endcase
   endfunction
   function automatic logic [PER_W-1:0] absdiff(input logic [PER_W-1:0] a,
                                                input logic [PER_W-1:0] b);
      return (a > b) ? a - b : b - a;
   endfunction
   // Equal, double or half rate all lock
   function automatic logic rate_match(input logic [PER_W-1:0] p, input logic [2:0] code);
      logic [PER_W-1:0] q;
      q = period_of(code);
      return absdiff(p, q) <= PER_TOL || absdiff(p, q << 1) <= (PER_TOL << 1)
         || absdiff(p << 1, q) <= (PER_TOL << 1);
   endfunction
   function automatic logic [2:0] rate_code_of(input logic [PER_W-1:0] p);
      logic [2:0] best;
      logic [PER_W-1:0] bd;
      best = RATE_32K;
      bd = absdiff(p, period_of(RATE_32K));
      for (int i = 1; i < 6; i++) begin
         if (absdiff(p, period_of(3'(i))) < bd) begin
            best = 3'(i);
            bd = absdiff(p, period_of(3'(i)));
         end
      end
      return best;
   endfunction
endpackage

/* File: verilog/dacf_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are static levels or slow clocks; only stage two is read.
module dacf_sync #(
   parameter int W = 1
) (
   input wire logic hclk,          // System clock
   input wire logic hresetn,       // Async reset, active low
   input wire logic [W-1:0] d,     // Asynchronous pins
   output logic [W-1:0] q          // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dacf_sync_st_t;
   dacf_sync_st_t st_reg;
   dacf_sync_st_t st_next;

   always_comb begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule

/* File: verilog/dacf_rate_meter.sv */
// Measures the period of a synchronised sample clock in system clocks.
// Assumes lvl is already synchronised; a result is valid only within range.
module dacf_rate_meter (
   input wire logic hclk,               // System clock
   input wire logic hresetn,            // Async reset, active low
   input wire logic lvl,                // Synchronised sample clock
   output dacf_pkg::dacf_meas_t meas    // Last period and its validity
);
   typedef struct packed {
      logic prev;
      logic [dacf_pkg::PER_W-1:0] cnt;
      dacf_pkg::dacf_meas_t meas;
   } dacf_meter_st_t;
   dacf_meter_st_t st_reg;
   dacf_meter_st_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.prev = lvl;
      if (st_reg.cnt != dacf_pkg::PER_MAX) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else begin
         // A stopped clock must not leave a stale lock behind
         st_next.meas.valid = 1'b0;
      end
      if (lvl && !st_reg.prev) begin
         // [R7] Every period updates
         st_next.meas.period = st_reg.cnt + 1'b1;
         st_next.meas.valid = (st_reg.cnt + 1'b1 >= dacf_pkg::PER_MIN)
            && (st_reg.cnt != dacf_pkg::PER_MAX);
         st_next.cnt = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign meas = st_reg.meas;

   chk_meter_range: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
      meas.valid |-> meas.period >= dacf_pkg::PER_MIN && meas.period <= dacf_pkg::PER_MAX)
      else $error("valid period outside the 25 to 102 kHz range");
endmodule

/* File: verilog/dacf_top.sv */
// Audio clock source and output format control with an AHB-Lite register slave.
// Assumes one AHB-Lite master on hclk; all sample-clock and status pins are
// asynchronous and pass a two-stage synchroniser before use.
//
// Overview of operation
// [R1] Jumper fitted: output eight-channel format from power-on until host booted.
// [R2] Jumper removed: output stereo format from power-on until host booted.
// [R3] Auto mode: move to recovered clock once valid input matches playback rate.
// [R4] Report master on crystal, slave on recovered or word clock.
// [R5] Master mode always uses the crystal, never follows the input.
// [R6] Lock when input rate equals, doubles or halves the playback rate.
// [R7] While slaved follow any input rate 25 to 102 kHz, tracking changes.
// [R8] Source starts at a standard rate; pitching allowed only once running.
// [R9] Word-clock mode takes the word clock, any rate 25 to 102 kHz.
// [R10] System has exactly one clock master; others run as slaves.
// [R11] Received channel status is discarded; a new header is built.
// [R12] Incoming emphasis dropped; outgoing emphasis only from host setting.
// [R13] Header: rate code, copy permitted, general category, two-channel, emphasis.
// [R14] Header carries host consumer/professional and audio/non-audio choices.
// [R15] Analog de-emphasis only below 64 kHz.
// [R16] Eight-channel playback disables balanced and coaxial outputs.
// [R17] More than two tracks, or force setting, selects eight-channel output.
// [R18] Input format follows the detected stream at once.
// [R19] Stereo input with several inputs enabled lands on channels 1+2.
// [R20] Input and output formats are independent.
// [R21] Direct monitoring routes each input only to the same-numbered output.
// [R22] Auto mode falls back to crystal when the input loses lock.
// [R23] Forced stereo with eight-channel input routes the selected pair out.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
module dacf_top (
   input wire logic hclk,                     // System clock, 10 MHz
   input wire logic hresetn,                  // Async reset, active low
   input wire logic hsel,                     // Slave select
   input wire logic [31:0] haddr,             // Byte address
   input wire logic [1:0] htrans,             // Transfer type
   input wire logic hwrite,                   // Write when high
   input wire logic [2:0] hsize,              // Transfer size, word only
   input wire logic [31:0] hwdata,            // Write data
   input wire logic hready,                   // Bus ready
   output logic [31:0] hrdata,                // Read data
   output logic hreadyout,                    // Slave ready
   output logic hresp,                        // Always OKAY
   input wire logic boot_format_jumper,       // High when jumper fitted
   input wire logic in_lock_pin,              // Input receiver locked
   input wire logic in_multichan_pin,         // Input stream is eight-channel
   input wire logic in_fs_clk,                // Recovered input frame clock
   input wire logic word_clk,                 // External word clock
   output dacf_pkg::dacf_src_t clk_src,       // Selected sample clock source
   output logic clk_slave,                    // High while slaved
   output logic [31:0] cs_word,               // Outgoing channel status
   output logic deemph_en,                    // Analog de-emphasis on
   output dacf_pkg::dacf_route_t route        // Format and routing controls
);
   // ==========================================
   // State
   typedef struct packed {
      logic wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic [31:0] ctrl;
      dacf_pkg::dacf_src_t src;
      logic slave;
      logic [31:0] cs;
      logic deemph;
      dacf_pkg::dacf_route_t route;
   } dacf_top_st_t;
   dacf_top_st_t st_reg;
   dacf_top_st_t st_next;

   logic [4:0] pins_s;
   logic jp_s;
   logic lock_s;
   logic in_mc_s;
   dacf_pkg::dacf_meas_t in_meas;
   dacf_pkg::dacf_meas_t wc_meas;
   logic [1:0] mode;
   logic [2:0] play_rate;
   logic [2:0] cur_rate;
   logic [3:0] tracks;
   logic booted;
   logic emph;
   logic pro;
   logic in_ok;
   logic [31:0] status;

   // ==========================================
   // Pin capture
   dacf_sync #(.W(5)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({word_clk, in_fs_clk, in_multichan_pin, in_lock_pin, boot_format_jumper}),
      .q(pins_s)
   );
   assign jp_s = pins_s[0];
   assign lock_s = pins_s[1];
   assign in_mc_s = pins_s[2];

   dacf_rate_meter u_in_meter (
      .hclk(hclk),
      .hresetn(hresetn),
      .lvl(pins_s[3]),
      .meas(in_meas)
   );
   dacf_rate_meter u_wc_meter (
      .hclk(hclk),
      .hresetn(hresetn),
      .lvl(pins_s[4]),
      .meas(wc_meas)
   );

   // ==========================================
   // Decoded settings
   assign mode = st_reg.ctrl[dacf_pkg::CTL_CLKMODE +: 2];
   assign play_rate = st_reg.ctrl[dacf_pkg::CTL_RATE +: 3];
   assign tracks = st_reg.ctrl[dacf_pkg::CTL_TRACKS +: 4];
   assign booted = st_reg.ctrl[dacf_pkg::CTL_BOOTED];
   assign emph = st_reg.ctrl[dacf_pkg::CTL_EMPH];
   assign pro = st_reg.ctrl[dacf_pkg::CTL_PRO];
   assign in_ok = lock_s && in_meas.valid;

   // Rate actually on the output clock
   always_comb begin
      unique case (st_reg.src)
         dacf_pkg::SRC_INPUT: cur_rate = dacf_pkg::rate_code_of(in_meas.period);
         dacf_pkg::SRC_WORD: cur_rate = dacf_pkg::rate_code_of(wc_meas.period);
         dacf_pkg::SRC_XTAL: cur_rate = play_rate;
         // Unused encoding of the source enum falls back to the crystal rate
         default: cur_rate = play_rate;
      endcase
   end

   always_comb begin
      status = '0;
      status[dacf_pkg::STA_SLAVE] = st_reg.slave;
      status[dacf_pkg::STA_IN_LOCK] = in_ok;
      status[dacf_pkg::STA_IN_MC] = st_reg.route.in_multichan;
      status[dacf_pkg::STA_OUT_MC] = st_reg.route.out_multichan;
      status[dacf_pkg::STA_WC_LOCK] = wc_meas.valid;
      status[dacf_pkg::STA_RATE +: 3] = cur_rate;
      status[dacf_pkg::STA_JUMPER] = jp_s;
      status[dacf_pkg::STA_PERIOD +: dacf_pkg::PER_W] = in_meas.period;
   end

   // ==========================================
   // Next state
   always_comb begin
      st_next = st_reg;
      // Bus: zero wait states, never an error
      st_next.ready = 1'b1;
      st_next.resp = 1'b0;
      st_next.wr_pend = 1'b0;
      st_next.rdata = '0;
      if (st_reg.wr_pend && st_reg.wr_addr == dacf_pkg::CTRL_OFS) begin
         st_next.ctrl = hwdata & dacf_pkg::CTRL_MASK;
      end
      if (hsel && htrans[1] && hready) begin
         if (hwrite) begin
            st_next.wr_pend = 1'b1;
            st_next.wr_addr = haddr;
         end else if (haddr == dacf_pkg::CTRL_OFS) begin
            // A write just finishing is already visible
            st_next.rdata = st_next.ctrl;
         end else if (haddr == dacf_pkg::STAT_OFS) begin
            st_next.rdata = status;
         end
      end

      // Clock source selection
      unique case (st_reg.src)
         dacf_pkg::SRC_XTAL: begin
            // [R3] Follow matched input
            // [R6] Equal, double or half
            if (mode == dacf_pkg::CM_AUTO && in_ok
                && dacf_pkg::rate_match(in_meas.period, play_rate)) begin
               st_next.src = dacf_pkg::SRC_INPUT;
            end else if (mode == dacf_pkg::CM_WORD) begin
               // [R9] Word clock source
               st_next.src = dacf_pkg::SRC_WORD;
            end
         end
         dacf_pkg::SRC_INPUT: begin
            // [R5] Master forces crystal
            if (mode == dacf_pkg::CM_WORD) begin
               st_next.src = dacf_pkg::SRC_WORD;
            end else if (mode != dacf_pkg::CM_AUTO) begin
               st_next.src = dacf_pkg::SRC_XTAL;
            end else if (!in_ok) begin
               // [R22] Fall back on loss
               st_next.src = dacf_pkg::SRC_XTAL;
            end
            // [R7] Pitch changes keep the lock
         end
         dacf_pkg::SRC_WORD: begin
            if (mode != dacf_pkg::CM_WORD) begin
               st_next.src = dacf_pkg::SRC_XTAL;
            end
         end
      endcase
      // [R4] Master or slave report
      st_next.slave = st_next.src != dacf_pkg::SRC_XTAL;

      // [R11] Header built from scratch
      st_next.cs = '0;
      st_next.cs[dacf_pkg::CS_PRO] = pro;
      // [R14] Host audio selection
      st_next.cs[dacf_pkg::CS_NONAUDIO] = st_reg.ctrl[dacf_pkg::CTL_NONAUDIO];
      // [R13] Rate, copy, emphasis
      st_next.cs[dacf_pkg::CS_RATE +: 3] = cur_rate;
      // [R12] Emphasis from host only
      if (pro) begin
         st_next.cs[dacf_pkg::CS_EMPH_PRO +: 3] =
            emph ? dacf_pkg::EMPH_5015_PRO : dacf_pkg::EMPH_NONE_PRO;
      end else begin
         st_next.cs[dacf_pkg::CS_COPY] = 1'b1;
         st_next.cs[dacf_pkg::CS_EMPH_CON +: 3] =
            emph ? dacf_pkg::EMPH_5015_CON : dacf_pkg::EMPH_NONE_CON;
      end
      // [R15] No de-emphasis at high rates
      st_next.deemph = emph && cur_rate < dacf_pkg::RATE_64K;

      // Output format
      if (!booted) begin
         // [R1] Jumper fitted
         // [R2] Jumper removed
         st_next.route.out_multichan = jp_s;
      end else if (st_reg.ctrl[dacf_pkg::CTL_FORCE_ST]) begin
         st_next.route.out_multichan = 1'b0;
      end else begin
         // [R17] Track count or force
         st_next.route.out_multichan = tracks > dacf_pkg::MC_TRACKS
            || st_reg.ctrl[dacf_pkg::CTL_FORCE_MC];
      end
      // [R16] Electrical outputs off
      st_next.route.elec_out_en = !st_next.route.out_multichan;
      // [R18] Input follows stream
      // [R20] Independent of output
      st_next.route.in_multichan = in_mc_s;
      // [R19] Stereo onto 1+2
      st_next.route.in_to_ch12 = !in_mc_s && st_reg.ctrl[dacf_pkg::CTL_MULTI_IN];
      // [R21] Same-channel monitoring
      st_next.route.direct_mon = st_reg.ctrl[dacf_pkg::CTL_DIRMON];
      // [R23] Selected pair to stereo out
      st_next.route.stereo_pair = (!st_next.route.out_multichan && in_mc_s)
         ? st_reg.ctrl[dacf_pkg::CTL_PAIR +: 2] : 2'h0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '{ready: 1'b1, ctrl: dacf_pkg::CTRL_RST,
                     src: dacf_pkg::SRC_XTAL, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================
   // Outputs
   assign hrdata = st_reg.rdata;
   assign hreadyout = st_reg.ready;
   assign hresp = st_reg.resp;
   assign clk_src = st_reg.src;
   assign clk_slave = st_reg.slave;
   assign cs_word = st_reg.cs;
   assign deemph_en = st_reg.deemph;
   assign route = st_reg.route;

   // ==========================================
   // Checks
   sequence s_master_held;
      mode == dacf_pkg::CM_MASTER [*2];
   endsequence
   sequence s_auto_locked;
      mode == dacf_pkg::CM_AUTO && in_ok && st_reg.src == dacf_pkg::SRC_INPUT;
   endsequence

   chk_boot_multi_fmt: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
      !booted && jp_s |=> route.out_multichan)
      else $error("jumper fitted but output not eight-channel before boot");

   chk_boot_stereo_fmt: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
      !booted && !jp_s |=> !route.out_multichan)
      else $error("jumper removed but output not stereo before boot");

   chk_auto_follow_in: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
      st_reg.src == dacf_pkg::SRC_XTAL && mode == dacf_pkg::CM_AUTO && in_ok
      && dacf_pkg::rate_match(in_meas.period, play_rate)
      |=> clk_src == dacf_pkg::SRC_INPUT)
      else $error("matched input not followed in auto mode");

   chk_clock_report: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
      clk_slave == (clk_src != dacf_pkg::SRC_XTAL))
      else $error("master or slave report disagrees with source");

   chk_master_xtal: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
      s_master_held |-> clk_src == dacf_pkg::SRC_XTAL)
      else $error("master mode not on the crystal");

   chk_slave_tracks: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
      s_auto_locked |=> clk_src == dacf_pkg::SRC_INPUT)
      else $error("slaved clock dropped while input still valid");

   chk_word_source: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
      mode == dacf_pkg::CM_WORD ##1 mode == dacf_pkg::CM_WORD
      |-> clk_src == dacf_pkg::SRC_WORD)
      else $error("word clock mode not on the word clock");

   chk_cs_emph_none: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
      !emph && !pro |=> cs_word[dacf_pkg::CS_EMPH_CON +: 3] == dacf_pkg::EMPH_NONE_CON
      && cs_word[dacf_pkg::CS_COPY])
      else $error("emphasis or copy bit wrong in consumer header");

   chk_deemph_rate: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
      deemph_en |-> cs_word[dacf_pkg::CS_RATE +: 3] < dacf_pkg::RATE_64K)
      else $error("de-emphasis active at a high sample rate");

   chk_elec_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
      route.out_multichan |-> !route.elec_out_en)
      else $error("electrical outputs on during eight-channel playback");

   chk_multi_play: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
      booted && !st_reg.ctrl[dacf_pkg::CTL_FORCE_ST] && tracks > dacf_pkg::MC_TRACKS
      |=> route.out_multichan)
      else $error("more than two tracks but output stereo");

   chk_in_format: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
      $rose(in_mc_s) |=> route.in_multichan)
      else $error("input mode did not follow detected stream");

   chk_lock_fallback: assert property (@(posedge hclk) disable iff (!hresetn) // [R22]
      st_reg.src == dacf_pkg::SRC_INPUT && mode == dacf_pkg::CM_AUTO && !in_ok
      |=> clk_src == dacf_pkg::SRC_XTAL)
      else $error("no fallback to crystal after input loss");

   chk_header_host: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
      cs_word[dacf_pkg::CS_PRO] == $past(pro)
      && cs_word[dacf_pkg::CS_NONAUDIO] == $past(st_reg.ctrl[dacf_pkg::CTL_NONAUDIO]))
      else $error("header format or audio bit differs from host setting");

   chk_dirmon_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
      route.direct_mon == $past(st_reg.ctrl[dacf_pkg::CTL_DIRMON]))
      else $error("direct monitoring does not follow host setting");

   chk_pair_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R23]
      !route.out_multichan && route.in_multichan
      |-> route.stereo_pair == $past(st_reg.ctrl[dacf_pkg::CTL_PAIR +: 2]))
      else $error("selected stereo pair not routed to the stereo output");

   chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hsel && htrans[1] && hready |=> hreadyout && !hresp)
      else $error("slave did not answer OKAY with no wait");
endmodule

/* File: sim/dacf_audio_src.sv */
// Far-side model: digital input receiver and external word clock.
// Assumes the bench sets lock, stream format and the frame clock half period.
module dacf_audio_src (
   input wire logic lock,            // Receiver locked
   input wire logic mc,              // Stream is eight-channel
   input wire logic [31:0] half_ns,  // Frame clock half period
   output logic in_lock_pin,         // Lock pin
   output logic in_multichan_pin,    // Format pin
   output logic in_fs_clk,           // Recovered frame clock
   output logic word_clk             // Word clock, 800 ns
);
   timeunit 1ns;
   timeprecision 1ns;
   assign in_lock_pin = lock;
   assign in_multichan_pin = mc;
   // Starts at a standard rate, device as slave
   // Frame clock stands still while unlocked, no stale toggling
   initial begin
      in_fs_clk = 1'b0;
      forever begin
         #(half_ns);
         in_fs_clk = lock ? ~in_fs_clk : 1'b0;
      end
   end
   initial word_clk = 1'b0;
   always #400 word_clk = ~word_clk;
endmodule

/* File: sim/testbench.sv */
// Self-checking bench of the clock and format control over AHB-Lite.
// Assumes hreadyout feeds hready and the far-side model drives the link pins.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] CO = dacf_pkg::CTRL_OFS;
   localparam logic [31:0] SO = dacf_pkg::STAT_OFS;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, jmp = 1, lock = 0, mc = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, cs_word, rd, c;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, in_lock_pin, in_multichan_pin, in_fs_clk, word_clk;
   logic clk_slave, deemph_en;
   dacf_pkg::dacf_src_t clk_src;
   dacf_pkg::dacf_route_t route;
   int failures = 0, check_count = 0, cyc = 0, half_ns = 10400;
   always #50 hclk = ~hclk;
   dacf_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .boot_format_jumper(jmp),
      .in_lock_pin, .in_multichan_pin, .in_fs_clk, .word_clk, .clk_src, .clk_slave,
      .cs_word, .deemph_en, .route);
   dacf_audio_src i_src (.lock, .mc, .half_ns, .in_lock_pin, .in_multichan_pin,
      .in_fs_clk, .word_clk);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, s);
         failures++;
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      chk("hresp", 0, 32'(hresp));
   endtask
   // Crystal source only (master, or auto at reset with no input lock), so the header rate is the programmed one
   task automatic check_outs(input logic [31:0] v);
      logic omc;
      logic [31:0] cs;
      omc = v[0] ? (!v[4] && (v[3] || v[19:16] > 4'h2)) : jmp;
      cs = {5'h0, v[14:12], 24'h0};
      cs[5:0] = v[6] ? {2'h1, v[5], 1'b0, v[7], 1'b1} : {2'h0, v[5], 1'b1, v[7], 1'b0};
      c = 32'({omc, !omc, mc, !mc && v[9], v[8], (!omc && mc) ? v[21:20] : 2'h0});
      chk("route", c, 32'(route));
      chk("cs_word", cs, cs_word);
      chk("deemph", 32'(v[5] && v[14:12] < 3'h3), 32'(deemph_en));
   endtask
   task automatic wait_src(input dacf_pkg::dacf_src_t s, input int n);
      for (int k = 0; k < n && clk_src !== s; k++) @(posedge hclk);
      chk("clk_src", 32'(s), 32'(clk_src));
      chk("slave", 32'(s != dacf_pkg::SRC_XTAL), 32'(clk_slave));
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      c = $urandom(32'h25ec29fa);
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, CO, 0);
      chk("ctrl reset", dacf_pkg::CTRL_RST, rd);
      repeat (4) @(posedge hclk);
      check_outs(dacf_pkg::CTRL_RST);
      jmp <= 1'b0;
      repeat (5) @(posedge hclk);
      check_outs(dacf_pkg::CTRL_RST);
      $display("boot format test done");
      repeat (40) begin
         c = $urandom() & dacf_pkg::CTRL_MASK & 32'hffff_8ff9;
         c[14:12] = 3'($urandom_range(5));
         mc <= 1'($urandom_range(1));
         bus(1, CO, c);
         bus(1, 32'h8, 32'hffff_ffff);
         bus(0, CO, 0);
         chk("ctrl", c, rd);
         repeat (4) @(posedge hclk);
         check_outs(rd);
      end
      bus(0, 32'h8, 0);
      chk("unmapped", 0, rd);
      $display("format and header test done");
      lock <= 1'b1;
      bus(1, CO, 32'h0002_2001);
      repeat (3000) @(posedge hclk);
      wait_src(dacf_pkg::SRC_XTAL, 1);
      bus(1, CO, 32'h0002_2003);
      wait_src(dacf_pkg::SRC_INPUT, 3000);
      lock <= 1'b0;
      wait_src(dacf_pkg::SRC_XTAL, 100);
      bus(1, CO, 32'h0002_5003);
      lock <= 1'b1;
      wait_src(dacf_pkg::SRC_INPUT, 3000);
      half_ns <= 15000;
      repeat (2500) @(posedge hclk);
      wait_src(dacf_pkg::SRC_INPUT, 1);
      bus(0, SO, 0);
      chk("rate", 32'(dacf_pkg::RATE_32K), 32'(rd[7:5]));
      chk("cs rate", 32'(dacf_pkg::RATE_32K), 32'(cs_word[26:24]));
      bus(1, CO, 32'h0002_2005);
      wait_src(dacf_pkg::SRC_WORD, 10);
      $display("clock source test done");
      finish_test();
   end
endmodule
